/* verilog/csm_regs.svh */
// register offsets, field positions, reset values and widths for chip sync and mode control
`ifndef CSM_REGS_SVH
`define CSM_REGS_SVH

// register indexes; byte address on the bus is four times the index
`define CSM_IDX_STAMP_DELAY 10'h123
`define CSM_IDX_SYNC_BEHAV 10'h1FF
`define CSM_IDX_CHAN_CFG 10'h200

// sysref_sync_behaviour fields
`define CSM_SYNC_MODE_BIT 0
`define CSM_SYNC_RESET 8'h00

// channel_path_configuration fields
`define CSM_CFG_Q_DROP_BIT 5
`define CSM_CFG_MODE_MSB 3
`define CSM_CFG_MODE_LSB 0
`define CSM_CFG_RESET 8'h00

// stamp_delay_cycles field
`define CSM_DELAY_MSB 6
`define CSM_DELAY_RESET 7'h40

// channel-configuration codes
`define CSM_MODE_FULL 4'h0
`define CSM_MODE_ONE 4'h1
`define CSM_MODE_TWO 4'h2
`define CSM_MODE_FOUR 4'h3

// downconverter enable patterns
`define CSM_DDC_NONE 4'h0
`define CSM_DDC_ONE 4'h1
`define CSM_DDC_TWO 4'h3
`define CSM_DDC_FOUR 4'hF

`endif

/* verilog/csm_pkg.sv */
// types shared by the chip sync and mode control block
package csm_pkg;

   typedef enum logic {
      CSM_SYNC_DIVIDERS,
      CSM_SYNC_STAMP
   } csm_sync_e;

   typedef struct packed {
      logic stamp;
      logic [13:0] q;
      logic [13:0] i;
   } csm_word_s;

   typedef struct packed {
      logic q_drop;
      logic [3:0] mode;
   } csm_cfg_s;

endpackage

/* verilog/csm_stamp_delay.sv */
// counts converter samples after a sysref event and flags the sample to be marked
`timescale 1ns/1ns
module csm_stamp_delay #(
   parameter int WIDTH = 7
) (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_event,
   input wire logic i_sample_valid,
   input wire logic [WIDTH-1:0] i_delay,
   output logic o_mark
);

   logic armed;
   logic [WIDTH-1:0] count;
   logic next_armed;
   logic [WIDTH-1:0] next_count;
   logic live;
   logic [WIDTH-1:0] cur;

   always_comb begin
      // a fresh event restarts the count; a pending one is given up
      live = i_event | armed;
      cur = i_event ? i_delay : count;
      o_mark = live & i_sample_valid & (cur == '0);
      next_armed = live & ~o_mark;
      next_count = cur;
      if (live && i_sample_valid && cur != '0) begin
         next_count = cur - 1'b1;
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         armed <= 1'b0;
         count <= '0;
      end else begin
         armed <= next_armed;
         count <= next_count;
      end
   end

endmodule // csm_stamp_delay

/* verilog/csm_top.sv */
// chip sync and mode control: registers, sysref handling and channel path selection
//
// Functional notes
// [RULE_01] sync mode: sysref resets every clock divider
// [RULE_02] sync mode: divider phase change drops link
// [RULE_03] stamp mode: dividers untouched by sysref
// [RULE_04] stamp mode: link and monitor undisturbed
// [RULE_05] stamp mode: sysref marks current sample word; the code marks the valid sample stamp delay samples later
// [RULE_06] q drop field: 0 I and Q, 1 I only
// [RULE_07] mode code 0000 is full bandwidth, reset
// [RULE_08] codes 1,2,3 enable one, two, four DDCs
// [RULE_09] seven bit stamp delay, 0..127 samples, reset 0x40
// [RULE_10] reserved bits read zero; reserved codes inert
`timescale 1ns/1ns
`include "csm_regs.svh"
module csm_top
   import csm_pkg::*;
#(
   parameter int SAMPLE_W = 14
) (
   input wire logic I_CLOCK,
   input wire logic I_RST,
   input wire logic I_WB_CYC,
   input wire logic I_WB_STB,
   input wire logic I_WB_WE,
   input wire logic [11:0] I_WB_ADR,
   input wire logic [3:0] I_WB_SEL,
   input wire logic [31:0] I_WB_DAT,
   output logic [31:0] O_WB_DAT,
   output logic O_WB_ACK,
   input wire logic I_SYSREF,
   input wire logic I_DIV_ALIGNED,
   input wire logic I_SAMPLE_VALID,
   input wire logic [SAMPLE_W-1:0] I_SAMPLE_I,
   input wire logic [SAMPLE_W-1:0] I_SAMPLE_Q,
   output csm_word_s O_WORD,
   output logic O_WORD_VALID,
   output logic O_Q_VALID,
   output logic O_DIV_RESET,
   output logic O_LINK_DROP,
   output logic O_MON_RESET,
   output logic [3:0] O_DDC_EN,
   output logic O_FULL_BW,
   output logic O_MODE_RESERVED,
   output logic O_SYNC_MODE
);

   ////////////////////////////////////////////////////////////////////////////////
   // registers and bus slave

   logic sync_mode;
   csm_cfg_s cfg;
   logic [`CSM_DELAY_MSB:0] delay;
   logic ack;
   logic [31:0] rdata;
   logic next_sync_mode;
   csm_cfg_s next_cfg;
   logic [`CSM_DELAY_MSB:0] next_delay;
   logic next_ack;
   logic [31:0] next_rdata;
   logic [9:0] idx;
   logic req;
   // full register images, so reset fields are picked by their bit positions
   localparam logic [7:0] SYNC_RST = `CSM_SYNC_RESET;
   localparam logic [7:0] CFG_RST = `CSM_CFG_RESET;

   always_comb begin
      idx = I_WB_ADR[11:2];
      // one-cycle answer; ack drops the cycle after it is given
      req = I_WB_CYC & I_WB_STB & ~ack;
      next_ack = req;
      next_sync_mode = sync_mode;
      next_cfg = cfg;
      next_delay = delay;
      next_rdata = 32'h0000_0000;
      if (req && I_WB_WE && I_WB_SEL[0]) begin
         unique case (idx)
            `CSM_IDX_SYNC_BEHAV: begin
               next_sync_mode = I_WB_DAT[`CSM_SYNC_MODE_BIT];
            end
            `CSM_IDX_CHAN_CFG: begin
               next_cfg.q_drop = I_WB_DAT[`CSM_CFG_Q_DROP_BIT]; // [RULE_06]
               next_cfg.mode = I_WB_DAT[`CSM_CFG_MODE_MSB:`CSM_CFG_MODE_LSB];
            end
            `CSM_IDX_STAMP_DELAY: begin
               next_delay = I_WB_DAT[`CSM_DELAY_MSB:0]; // [RULE_09]
            end
            default: begin
               // unmapped writes are acked and dropped
               next_delay = delay;
            end
         endcase
      end
      if (req && !I_WB_WE) begin
         // reserved bits and unmapped words read as zero [RULE_10]
         unique case (idx)
            `CSM_IDX_SYNC_BEHAV: begin
               next_rdata[`CSM_SYNC_MODE_BIT] = sync_mode;
            end
            `CSM_IDX_CHAN_CFG: begin
               next_rdata[`CSM_CFG_Q_DROP_BIT] = cfg.q_drop;
               next_rdata[`CSM_CFG_MODE_MSB:`CSM_CFG_MODE_LSB] = cfg.mode;
            end
            `CSM_IDX_STAMP_DELAY: begin
               next_rdata[`CSM_DELAY_MSB:0] = delay;
            end
            default: begin
               next_rdata = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         sync_mode <= SYNC_RST[`CSM_SYNC_MODE_BIT];
         cfg.q_drop <= CFG_RST[`CSM_CFG_Q_DROP_BIT];
         cfg.mode <= CFG_RST[`CSM_CFG_MODE_MSB:`CSM_CFG_MODE_LSB]; // [RULE_07]
         delay <= `CSM_DELAY_RESET; // [RULE_09]
         ack <= 1'b0;
         rdata <= 32'h0000_0000;
      end else begin
         sync_mode <= next_sync_mode;
         cfg <= next_cfg;
         delay <= next_delay;
         ack <= next_ack;
         rdata <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // sysref synchroniser and event detect

   logic [2:0] sref_sync;
   logic sref_level;
   logic [2:0] next_sref_sync;
   logic next_sref_level;
   logic sref_event;
   csm_sync_e sync_sel;

   always_comb begin
      next_sref_sync = {sref_sync[1:0], I_SYSREF};
      // stage 0 feeds stage 1 only; a change counts once stages 1 and 2 agree
      next_sref_level = sref_level;
      if (sref_sync[1] == sref_sync[2]) begin
         next_sref_level = sref_sync[2];
      end
      sref_event = next_sref_level & ~sref_level;
      sync_sel = sync_mode ? CSM_SYNC_STAMP : CSM_SYNC_DIVIDERS;
   end

   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         sref_sync <= 3'h0;
         sref_level <= 1'b0;
      end else begin
         sref_sync <= next_sref_sync;
         sref_level <= next_sref_level;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // divider reset, link drop and monitor

   logic div_reset;
   logic link_drop;
   logic mon_reset;
   logic next_div_reset;
   logic next_link_drop;
   logic next_mon_reset;
   logic stamp_event;

   always_comb begin
      next_div_reset = 1'b0;
      next_link_drop = 1'b0;
      next_mon_reset = 1'b0;
      stamp_event = 1'b0;
      unique case (sync_sel)
         CSM_SYNC_DIVIDERS: begin
            next_div_reset = sref_event; // [RULE_01]
            // a misaligned divider is forced to move, so the link must retrain
            next_link_drop = sref_event & ~I_DIV_ALIGNED; // [RULE_02]
            next_mon_reset = sref_event;
         end
         CSM_SYNC_STAMP: begin
            // dividers, link and monitor see nothing [RULE_03] [RULE_04]
            stamp_event = sref_event; // [RULE_05]
         end
      endcase
   end

   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         div_reset <= 1'b0;
         link_drop <= 1'b0;
         mon_reset <= 1'b0;
      end else begin
         div_reset <= next_div_reset;
         link_drop <= next_link_drop;
         mon_reset <= next_mon_reset;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // sample path with timestamp mark and component selection

   logic mark;
   csm_word_s word;
   logic word_valid;
   logic q_valid;
   csm_word_s next_word;
   logic next_word_valid;
   logic next_q_valid;

   csm_stamp_delay #(
      .WIDTH(`CSM_DELAY_MSB + 1)
   ) u_stamp_delay (
      .i_clock(I_CLOCK),
      .i_rst(I_RST),
      .i_event(stamp_event),
      .i_sample_valid(I_SAMPLE_VALID),
      .i_delay(delay), // [RULE_09]
      .o_mark(mark)
   );

   always_comb begin
      next_word_valid = I_SAMPLE_VALID;
      next_word = word;
      next_q_valid = 1'b0;
      if (I_SAMPLE_VALID) begin
         next_word.i = I_SAMPLE_I;
         // q is zeroed rather than held so a dropped stream carries no stale data
         next_word.q = cfg.q_drop ? '0 : I_SAMPLE_Q; // [RULE_06]
         next_q_valid = ~cfg.q_drop; // [RULE_06]
         next_word.stamp = mark; // [RULE_05]
      end
   end

   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         word <= '0;
         word_valid <= 1'b0;
         q_valid <= 1'b0;
      end else begin
         word <= next_word;
         word_valid <= next_word_valid;
         q_valid <= next_q_valid;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // channel configuration decode

   logic [3:0] ddc_en;
   logic full_bw;
   logic mode_reserved;
   logic [3:0] next_ddc_en;
   logic next_full_bw;
   logic next_mode_reserved;

   always_comb begin
      next_ddc_en = `CSM_DDC_NONE;
      next_full_bw = 1'b0;
      next_mode_reserved = 1'b0;
      unique case (cfg.mode)
         `CSM_MODE_FULL: next_full_bw = 1'b1; // [RULE_07]
         `CSM_MODE_ONE: next_ddc_en = `CSM_DDC_ONE; // [RULE_08]
         `CSM_MODE_TWO: next_ddc_en = `CSM_DDC_TWO; // [RULE_08]
         `CSM_MODE_FOUR: next_ddc_en = `CSM_DDC_FOUR; // [RULE_08]
         default: next_mode_reserved = 1'b1; // [RULE_10]
      endcase
   end

   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         ddc_en <= `CSM_DDC_NONE;
         full_bw <= 1'b1;
         mode_reserved <= 1'b0;
      end else begin
         ddc_en <= next_ddc_en;
         full_bw <= next_full_bw;
         mode_reserved <= next_mode_reserved;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs, all from flip-flops

   assign O_WB_DAT = rdata;
   assign O_WB_ACK = ack;
   assign O_WORD = word;
   assign O_WORD_VALID = word_valid;
   assign O_Q_VALID = q_valid;
   assign O_DIV_RESET = div_reset;
   assign O_LINK_DROP = link_drop;
   assign O_MON_RESET = mon_reset;
   assign O_DDC_EN = ddc_en;
   assign O_FULL_BW = full_bw;
   assign O_MODE_RESERVED = mode_reserved;
   assign O_SYNC_MODE = sync_mode;

endmodule // csm_top

/* bench/csm_conv_model.sv */
// converter side model: sysref pulses and a running sample stream
`timescale 1ns/1ns
module csm_conv_model (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_fire,
   output logic o_sysref,
   output logic o_valid,
   output logic [13:0] o_i,
   output logic [13:0] o_q
);
   logic [2:0] hold;
   logic [13:0] cnt;
   // sysref held four cycles so the three-stage filter sees a clean level
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         hold <= 3'h0;
         cnt <= 14'h0;
      end else begin
         hold <= i_fire ? 3'h4 : hold - 3'(hold != 3'h0);
         cnt <= cnt + 14'h1;
      end
   end
   assign o_sysref = hold != 3'h0;
   // one sample every other cycle, so the stamp count is not just a cycle count
   assign o_valid = cnt[0];
   assign o_i = cnt;
   assign o_q = ~cnt;
endmodule // csm_conv_model

/* bench/csm_top_assertions.sv */
// checker: properties on the ports of the chip sync and mode control block
`timescale 1ns/1ns
module csm_top_checker
   import csm_pkg::*;
(
   input wire logic I_CLOCK,
   input wire logic I_RST,
   input wire logic I_WB_CYC,
   input wire logic I_WB_STB,
   input wire logic [31:0] O_WB_DAT,
   input wire logic O_WB_ACK,
   input wire csm_word_s O_WORD,
   input wire logic O_WORD_VALID,
   input wire logic O_Q_VALID,
   input wire logic O_DIV_RESET,
   input wire logic O_LINK_DROP,
   input wire logic O_MON_RESET,
   input wire logic [3:0] O_DDC_EN,
   input wire logic O_FULL_BW,
   input wire logic O_MODE_RESERVED,
   input wire logic O_SYNC_MODE
);
   default clocking @(posedge I_CLOCK);
   endclocking
   default disable iff (I_RST);
   property p_ack;
      I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK ##1 !O_WB_ACK;
   endproperty
   a_ack: assert property (p_ack) else $error("bus ack late or too long");
   property p_upper;
      O_WB_DAT[31:8] == 24'h00_0000;
   endproperty
   a_upper: assert property (p_upper) else $error("upper read bits set");
   property p_div;
      O_DIV_RESET |-> O_MON_RESET && !O_SYNC_MODE;
   endproperty
   a_div: assert property (p_div) else $error("divider reset mismatch");
   property p_link;
      O_LINK_DROP |-> O_DIV_RESET;
   endproperty
   a_link: assert property (p_link) else $error("link drop without event");
   property p_keep;
      O_SYNC_MODE |-> !O_DIV_RESET;
   endproperty
   a_keep: assert property (p_keep) else $error("divider reset in stamp mode");
   property p_quiet;
      O_SYNC_MODE |-> !O_LINK_DROP && !O_MON_RESET;
   endproperty
   a_quiet: assert property (p_quiet) else $error("link or monitor hit");
   property p_stamp;
      $rose(O_WORD.stamp) |-> O_WORD_VALID && O_SYNC_MODE;
   endproperty
   a_stamp: assert property (p_stamp) else $error("stray stamp bit");
   property p_q;
      O_WORD_VALID && !O_Q_VALID |-> O_WORD.q == 14'h0;
   endproperty
   a_q: assert property (p_q) else $error("dropped q not zero");
   property p_full;
      O_FULL_BW |-> O_DDC_EN == 4'h0 && !O_MODE_RESERVED;
   endproperty
   a_full: assert property (p_full) else $error("full bandwidth with ddc");
   property p_ddc;
      O_DDC_EN inside {4'h0, 4'h1, 4'h3, 4'hF};
   endproperty
   a_ddc: assert property (p_ddc) else $error("bad ddc pattern");
endmodule // csm_top_checker
bind csm_top csm_top_checker csm_top_checker_inst (.I_CLOCK(I_CLOCK), .I_RST(I_RST),
   .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK),
   .O_WORD(O_WORD), .O_WORD_VALID(O_WORD_VALID), .O_Q_VALID(O_Q_VALID),
   .O_DIV_RESET(O_DIV_RESET), .O_LINK_DROP(O_LINK_DROP), .O_MON_RESET(O_MON_RESET),
   .O_DDC_EN(O_DDC_EN), .O_FULL_BW(O_FULL_BW), .O_MODE_RESERVED(O_MODE_RESERVED),
   .O_SYNC_MODE(O_SYNC_MODE));

/* bench/chip_sync_and_mode_control_tb_top.sv */
// testbench: register access, sysref handling and sample path
`timescale 1ns/1ns
module chip_sync_and_mode_control_tb_top;
   import csm_pkg::*;
   logic clk, rst, cyc, stb, we, fire, algn, sv, ack, wv, qv, divr, ldrop, monr, fbw, mres, sm;
   logic sref;
   logic [11:0] adr;
   logic [31:0] wd, dat, rdat;
   logic [13:0] si, sq;
   logic [3:0] ddc;
   csm_word_s word;
   int fails, n_tests, ndiv, nlink, nmon, nstamp, nqv, nwv;
   logic [3:0] ddc_exp [4] = '{4'h0, 4'h1, 4'h3, 4'hF};
   csm_top csm_top_inst (.I_CLOCK(clk), .I_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb),
      .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'hF), .I_WB_DAT(wd), .O_WB_DAT(dat),
      .O_WB_ACK(ack), .I_SYSREF(sref), .I_DIV_ALIGNED(algn), .I_SAMPLE_VALID(sv),
      .I_SAMPLE_I(si), .I_SAMPLE_Q(sq), .O_WORD(word), .O_WORD_VALID(wv), .O_Q_VALID(qv),
      .O_DIV_RESET(divr), .O_LINK_DROP(ldrop), .O_MON_RESET(monr), .O_DDC_EN(ddc),
      .O_FULL_BW(fbw), .O_MODE_RESERVED(mres), .O_SYNC_MODE(sm));
   csm_conv_model csm_conv_model_inst (.i_clock(clk), .i_rst(rst), .i_fire(fire),
      .o_sysref(sref), .o_valid(sv), .o_i(si), .o_q(sq));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
         fails++;
      end
   endtask
   // single classic cycle; waits for ack, only the watchdog ends a dead slave
   task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] v);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wd <= v;
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      rdat = dat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0000_0000);
      chk(rdat, e);
   endtask
   // fire one sysref and count the resulting pulses over a fixed window
   task automatic ev(input logic al);
      @(posedge clk);
      fire <= 1'b1;
      algn <= al;
      @(posedge clk);
      fire <= 1'b0;
      {ndiv, nlink, nmon, nstamp, nqv, nwv} = '0;
      for (int j = 0; j < 40; j++) begin
         @(posedge clk);
         #1;
         ndiv += divr;
         nlink += ldrop;
         nmon += monr;
         // words of samples from the event edge on, up to and with the stamped one
         if (j >= 3 && nstamp == 0) nwv += wv;
         nstamp += wv & word.stamp;
         nqv += qv;
      end
   endtask
   task automatic final_report;
      if (fails == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #200000;
      fails++;
      final_report;
   end
   initial begin
      {rst, cyc, stb, we, fire, algn, adr, wd} = '0;
      rst = 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk(fbw, 1);
      rd(12'h7FC, 32'h0000_0000);
      rd(12'h800, 32'h0000_0000);
      rd(12'h48C, 32'h0000_0040);
      wb(1'b1, 12'h7FC, 32'h0000_00FF);
      rd(12'h7FC, 32'h0000_0001);
      wb(1'b1, 12'h800, 32'h0000_00FF);
      rd(12'h800, 32'h0000_002F);
      chk({ddc, mres, fbw}, 6'h02);
      rd(12'h004, 32'h0000_0000);
      wb(1'b1, 12'h48C, 32'h0000_00FF);
      rd(12'h48C, 32'h0000_007F);
      for (int i = 0; i < 4; i++) begin
         wb(1'b1, 12'h800, 32'(i));
         rd(12'h800, 32'(i));
         chk({ddc, fbw}, {ddc_exp[i], i == 0});
      end
      wb(1'b1, 12'h7FC, 32'h0000_0000);
      ev(1'b0);
      chk(ndiv, 1);
      chk(nmon, 1);
      chk(nlink, 1);
      ev(1'b1);
      chk(nlink, 0);
      wb(1'b1, 12'h7FC, 32'h0000_0001);
      chk(sm, 1);
      wb(1'b1, 12'h48C, 32'h0000_0003);
      ev(1'b0);
      chk(ndiv, 0);
      chk(nlink + nmon, 0);
      chk(nstamp, 1);
      chk(nwv, 4);
      chk(nqv != 0, 1);
      wb(1'b1, 12'h800, 32'h0000_0020);
      ev(1'b0);
      chk(nqv, 0);
      chk(word.q, 0);
      final_report;
   end
endmodule // chip_sync_and_mode_control_tb_top
